// ===== core/sab_core.sv
// Module: auto-baud measuring serial port with its receiver and transmitter
module sab_core (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Configuration
    input wire sab_pkg::sab_cfg_t cfg,
    // Software strobes
    input wire logic autobaud_enable_set,
    input wire logic divisor_write,
    input wire logic [15:0] divisor_wdata,
    input wire logic receive_buffer_read,
    input wire logic tx_load,
    input wire logic [8:0] tx_data,
    // Serial lines
    input wire logic rx_line,
    output logic tx_line,
    // Status
    output logic autobaud_enable,
    output logic [7:0] divisor_low_byte,
    output logic [7:0] divisor_high_byte,
    output logic receive_complete_flag,
    output logic [8:0] receive_buffer,
    output logic framing_error,
    output logic receiver_idle,
    output logic tx_busy
);
    import sab_pkg::*;

    // Measurement group
    sab_cal_st_t cal_st_r, cal_st_nxt;
    logic [2:0] edge_r, edge_nxt;
    logic [12:0] pre_r, pre_nxt;
    logic [7:0] lo_r, lo_nxt, hi_r, hi_nxt;
    logic en_r, en_nxt;
    logic rx_prev_r;
    logic rx_rise, cal_done, cal_busy;
    logic [12:0] cal_period;
    logic [8:0] lo_inc;

    assign rx_rise = rx_line & ~rx_prev_r;
    assign cal_busy = (cal_st_r != SAB_CAL_IDLE);
    assign cal_period = sab_cal_period(cfg.wide_divisor_select,
                                       cfg.high_speed_rate_select);
    assign lo_inc = {1'b0, lo_r} + 9'h001;

    always_comb begin
        cal_st_nxt = cal_st_r;
        edge_nxt = edge_r;
        pre_nxt = pre_r;
        lo_nxt = lo_r;
        hi_nxt = hi_r;
        en_nxt = en_r;
        cal_done = 1'b0;
        // Software writes are ignored while a measurement owns the divisor
        if (divisor_write && !cal_busy) begin
            lo_nxt = divisor_wdata[7:0];
            hi_nxt = divisor_wdata[15:8];
        end
        if (autobaud_enable_set && cfg.async_mode && !en_r) begin
            en_nxt = 1'b1;
            lo_nxt = SAB_BYTE_RST;
            hi_nxt = SAB_BYTE_RST;
            pre_nxt = '0;
            edge_nxt = '0;
            // Break first when wake-on-break is set
            cal_st_nxt = cfg.wake_on_break_enable ? SAB_CAL_BRK_LOW
                                                  : SAB_CAL_START;
        end else if (cal_busy && !cfg.async_mode) begin
            en_nxt = 1'b0;
            cal_st_nxt = SAB_CAL_IDLE;
        end else begin
            unique case (cal_st_r)
                SAB_CAL_IDLE: begin
                end
                SAB_CAL_BRK_LOW: begin
                    if (!rx_line) begin
                        cal_st_nxt = SAB_CAL_BRK_END;
                    end
                end
                SAB_CAL_BRK_END: begin
                    if (rx_rise) begin
                        cal_st_nxt = SAB_CAL_START;
                    end
                end
                SAB_CAL_START: begin
                    if (!rx_line) begin
                        cal_st_nxt = SAB_CAL_EDGE;
                    end
                end
                SAB_CAL_EDGE: begin
                    if (rx_rise) begin
                        edge_nxt = 3'h1;
                        pre_nxt = '0;
                        cal_st_nxt = SAB_CAL_COUNT;
                    end
                end
                SAB_CAL_COUNT: begin
                    // Edges 1 to 5 bracket four low and four high bits
                    if (pre_r == cal_period - 13'h0001) begin
                        pre_nxt = '0;
                        if (cfg.wide_divisor_select) begin
                            {hi_nxt, lo_nxt} = {hi_r, lo_r} + 16'h0001;
                        end else begin
                            lo_nxt = lo_inc[7:0];
                            if (lo_inc[8]) begin
                                hi_nxt = hi_r | SAB_HI_CARRY;
                            end
                        end
                    end else begin
                        pre_nxt = pre_r + 13'h0001;
                    end
                    if (rx_rise) begin
                        edge_nxt = edge_r + 3'h1;
                        if (edge_r == SAB_EDGES - 3'h1) begin
                            en_nxt = 1'b0;
                            cal_done = 1'b1;
                            cal_st_nxt = SAB_CAL_IDLE;
                        end
                    end
                end
                default: cal_st_nxt = SAB_CAL_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cal_st_r <= SAB_CAL_IDLE;
            edge_r <= '0;
            pre_r <= '0;
            lo_r <= SAB_BYTE_RST;
            hi_r <= SAB_BYTE_RST;
            en_r <= 1'b0;
            rx_prev_r <= 1'b1;
        end else begin
            cal_st_r <= cal_st_nxt;
            edge_r <= edge_nxt;
            pre_r <= pre_nxt;
            lo_r <= lo_nxt;
            hi_r <= hi_nxt;
            en_r <= en_nxt;
            rx_prev_r <= rx_line;
        end
    end

    // Baud tick group: stopped while the generator serves as the timer
    logic [15:0] tick_cnt_r, tick_cnt_nxt;
    logic tick_r, tick_nxt;
    logic [15:0] tick_period;

    assign tick_period = cfg.wide_divisor_select ? {hi_r, lo_r}
                                                 : {8'h00, lo_r};

    always_comb begin
        tick_cnt_nxt = tick_cnt_r;
        tick_nxt = 1'b0;
        if (cal_busy || divisor_write) begin
            tick_cnt_nxt = tick_period;
        end else if (tick_cnt_r == 16'h0000) begin
            tick_cnt_nxt = tick_period;
            tick_nxt = 1'b1;
        end else begin
            tick_cnt_nxt = tick_cnt_r - 16'h0001;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            tick_cnt_r <= '0;
            tick_r <= 1'b0;
        end else begin
            tick_cnt_r <= tick_cnt_nxt;
            tick_r <= tick_nxt;
        end
    end

    logic [6:0] tpb;
    assign tpb = sab_ticks(cfg.wide_divisor_select, cfg.high_speed_rate_select);

    // Receiver group
    sab_rx_st_t rx_st_r, rx_st_nxt;
    logic [6:0] rx_cnt_r, rx_cnt_nxt;
    logic [3:0] rx_bit_r, rx_bit_nxt;
    logic [8:0] rx_sh_r, rx_sh_nxt, rx_buf_r, rx_buf_nxt;
    logic fe_r, fe_nxt, rx_done;
    logic [3:0] rx_bits;

    assign rx_bits = cfg.nine_bit ? SAB_BITS_9 : SAB_BITS_8;

    always_comb begin
        rx_st_nxt = rx_st_r;
        rx_cnt_nxt = rx_cnt_r;
        rx_bit_nxt = rx_bit_r;
        rx_sh_nxt = rx_sh_r;
        rx_buf_nxt = rx_buf_r;
        fe_nxt = fe_r;
        rx_done = 1'b0;
        if (cal_busy || !cfg.rx_enable) begin
            rx_st_nxt = SAB_RX_IDLE;
        end else begin
            unique case (rx_st_r)
                SAB_RX_IDLE: begin
                    if (!rx_line) begin
                        rx_st_nxt = SAB_RX_START;
                        rx_cnt_nxt = '0;
                    end
                end
                SAB_RX_START: begin
                    if (tick_r) begin
                        // Recheck at mid start bit to reject glitches
                        if (rx_cnt_r == (tpb >> 1) - 7'h01) begin
                            rx_cnt_nxt = '0;
                            rx_bit_nxt = '0;
                            rx_st_nxt = rx_line ? SAB_RX_IDLE : SAB_RX_DATA;
                        end else begin
                            rx_cnt_nxt = rx_cnt_r + 7'h01;
                        end
                    end
                end
                SAB_RX_DATA: begin
                    if (tick_r) begin
                        if (rx_cnt_r == tpb - 7'h01) begin
                            rx_cnt_nxt = '0;
                            rx_sh_nxt = {rx_line, rx_sh_r[8:1]};
                            rx_bit_nxt = rx_bit_r + 4'h1;
                            if (rx_bit_r == rx_bits - 4'h1) begin
                                rx_st_nxt = SAB_RX_STOP;
                            end
                        end else begin
                            rx_cnt_nxt = rx_cnt_r + 7'h01;
                        end
                    end
                end
                SAB_RX_STOP: begin
                    if (tick_r) begin
                        if (rx_cnt_r == tpb - 7'h01) begin
                            rx_buf_nxt = cfg.nine_bit ? rx_sh_r
                                                      : {1'b0, rx_sh_r[8:1]};
                            fe_nxt = ~rx_line;
                            rx_done = 1'b1;
                            rx_st_nxt = SAB_RX_IDLE;
                        end else begin
                            rx_cnt_nxt = rx_cnt_r + 7'h01;
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rx_st_r <= SAB_RX_IDLE;
            rx_cnt_r <= '0;
            rx_bit_r <= '0;
            rx_sh_r <= '0;
            rx_buf_r <= '0;
            fe_r <= 1'b0;
        end else begin
            rx_st_r <= rx_st_nxt;
            rx_cnt_r <= rx_cnt_nxt;
            rx_bit_r <= rx_bit_nxt;
            rx_sh_r <= rx_sh_nxt;
            rx_buf_r <= rx_buf_nxt;
            fe_r <= fe_nxt;
        end
    end

    // Flag group: a new event wins over a read in the same cycle
    logic flag_r, flag_nxt, idle_r, idle_nxt;

    always_comb begin
        flag_nxt = (flag_r & ~receive_buffer_read) | cal_done | rx_done;
        idle_nxt = (rx_st_nxt == SAB_RX_IDLE);
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            flag_r <= 1'b0;
            idle_r <= 1'b1;
        end else begin
            flag_r <= flag_nxt;
            idle_r <= idle_nxt;
        end
    end

    // Transmitter group; it pauses while the tick is stopped
    logic [10:0] tx_sh_r, tx_sh_nxt;
    logic [3:0] tx_left_r, tx_left_nxt;
    logic [6:0] tx_cnt_r, tx_cnt_nxt;
    logic tx_line_r, tx_line_nxt, tx_busy_r, tx_busy_nxt;

    always_comb begin
        tx_sh_nxt = tx_sh_r;
        tx_left_nxt = tx_left_r;
        tx_cnt_nxt = tx_cnt_r;
        tx_busy_nxt = tx_busy_r;
        tx_line_nxt = tx_line_r;
        if (!tx_busy_r) begin
            tx_line_nxt = 1'b1;
            if (tx_load) begin
                tx_sh_nxt = cfg.nine_bit ? {1'b1, tx_data, 1'b0}
                                         : {2'b11, tx_data[7:0], 1'b0};
                tx_left_nxt = cfg.nine_bit ? SAB_TX_BITS_9 : SAB_TX_BITS_8;
                tx_cnt_nxt = '0;
                tx_busy_nxt = 1'b1;
            end
        end else begin
            tx_line_nxt = tx_sh_r[0];
            if (tick_r) begin
                if (tx_cnt_r == tpb - 7'h01) begin
                    tx_cnt_nxt = '0;
                    tx_sh_nxt = {1'b1, tx_sh_r[10:1]};
                    tx_left_nxt = tx_left_r - 4'h1;
                    if (tx_left_r == 4'h1) begin
                        tx_busy_nxt = 1'b0;
                    end
                end else begin
                    tx_cnt_nxt = tx_cnt_r + 7'h01;
                end
            end
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            tx_sh_r <= '1;
            tx_left_r <= '0;
            tx_cnt_r <= '0;
            tx_line_r <= 1'b1;
            tx_busy_r <= 1'b0;
        end else begin
            tx_sh_r <= tx_sh_nxt;
            tx_left_r <= tx_left_nxt;
            tx_cnt_r <= tx_cnt_nxt;
            tx_line_r <= tx_line_nxt;
            tx_busy_r <= tx_busy_nxt;
        end
    end

    assign tx_line = tx_line_r;
    assign tx_busy = tx_busy_r;
    assign autobaud_enable = en_r;
    assign divisor_low_byte = lo_r;
    assign divisor_high_byte = hi_r;
    assign receive_complete_flag = flag_r;
    assign receive_buffer = rx_buf_r;
    assign framing_error = fe_r;
    assign receiver_idle = idle_r;
endmodule : sab_core

// ===== core/sab_pkg.sv
// Package: constants, types and helpers for the auto-baud serial port core
// Operation
// - Measurement runs only in asynchronous mode, with the break first when wake-on-break is set.
// - A start bit with auto-baud enable set begins the measurement.
// - The baud generator counts time instead of making the bit clock.
// - Setting auto-baud enable clears the divisor, then waits for a start bit.
// - Counting begins at the first rising receive edge after the start bit.
// - Fifth rising edge leaves the period in the divisor, clears enable.
// - The count spans low and high bit times, averaging asymmetry.
// - The divisor counter ticks at one eighth of the counter clock.
// - Low and high divisor bytes form one 16-bit counter only when wide.
// - In 8-bit modes the high byte catches low-byte carry; 00h means none.
// - The normal receiver is held idle during measurement.
// - The receive-complete flag rises at the fifth rising edge.
// - Reading the receive buffer clears the receive-complete flag.
// - With wake-on-break set, measure the character after the break.
// - Counter clock: oscillator divided by 512, 256, 128 or 32.
// - Frames are LSB first: start, eight or nine data bits, stop.
package sab_pkg;
    localparam int SAB_DIV_W = 16;
    localparam logic [7:0] SAB_SYNC_CHAR = 8'h55;
    localparam logic [7:0] SAB_BYTE_RST = 8'h00;
    localparam logic [7:0] SAB_HI_CARRY = 8'h01;
    localparam logic [2:0] SAB_EDGES = 3'h5;
    localparam int SAB_CAL_SHIFT = 3;
    localparam logic [12:0] SAB_PRE_512 = 13'h0200;
    localparam logic [12:0] SAB_PRE_256 = 13'h0100;
    localparam logic [12:0] SAB_PRE_128 = 13'h0080;
    localparam logic [12:0] SAB_PRE_32 = 13'h0020;
    localparam logic [6:0] SAB_TPB_SLOW = 7'h40;
    localparam logic [6:0] SAB_TPB_MID = 7'h10;
    localparam logic [6:0] SAB_TPB_FAST = 7'h04;
    localparam logic [3:0] SAB_BITS_8 = 4'h8;
    localparam logic [3:0] SAB_BITS_9 = 4'h9;
    localparam logic [3:0] SAB_TX_BITS_8 = 4'ha;
    localparam logic [3:0] SAB_TX_BITS_9 = 4'hb;

    typedef enum logic [2:0] {
        SAB_CAL_IDLE = 3'b000,
        SAB_CAL_BRK_LOW = 3'b001,
        SAB_CAL_BRK_END = 3'b010,
        SAB_CAL_START = 3'b011,
        SAB_CAL_EDGE = 3'b100,
        SAB_CAL_COUNT = 3'b101
    } sab_cal_st_t;

    typedef enum logic [1:0] {
        SAB_RX_IDLE = 2'b00,
        SAB_RX_START = 2'b01,
        SAB_RX_DATA = 2'b10,
        SAB_RX_STOP = 2'b11
    } sab_rx_st_t;

    typedef struct packed {
        logic async_mode;
        logic wake_on_break_enable;
        logic wide_divisor_select;
        logic high_speed_rate_select;
        logic nine_bit;
        logic rx_enable;
    } sab_cfg_t;

    // Measurement tick period in oscillator cycles, including the 1/8 rate
    function automatic logic [12:0] sab_cal_period(input logic wide,
                                                   input logic fast);
        logic [12:0] pre;
        unique case ({wide, fast})
            2'b00: pre = SAB_PRE_512;
            2'b01: pre = SAB_PRE_256;
            2'b10: pre = SAB_PRE_128;
            2'b11: pre = SAB_PRE_32;
        endcase
        return pre << SAB_CAL_SHIFT;
    endfunction : sab_cal_period

    // Baud ticks per bit for the normal serial paths
    function automatic logic [6:0] sab_ticks(input logic wide,
                                             input logic fast);
        logic [6:0] t;
        unique case ({wide, fast})
            2'b00: t = SAB_TPB_SLOW;
            2'b01: t = SAB_TPB_MID;
            2'b10: t = SAB_TPB_MID;
            2'b11: t = SAB_TPB_FAST;
        endcase
        return t;
    endfunction : sab_ticks
endpackage : sab_pkg

// ===== bench/sab_remote_tx.sv
// Partner model: remote transmitter sending one frame per request
module sab_remote_tx (
    // Clock
    input wire logic clk,
    // Frame request
    input wire logic go,
    input wire logic brk,
    input wire logic [7:0] data,
    input wire logic [15:0] bit_cyc,
    // Line and status
    output logic rx_line,
    output logic done
);
    timeunit 1ns;
    timeprecision 100ps;

    task automatic hold(input logic v, input int n);
        rx_line = v;
        repeat (n) @(negedge clk);
    endtask : hold

    // Line idles at mark level between frames, as a real sender does
    initial begin
        rx_line = 1'b1;
        done = 1'b0;
        forever begin
            @(posedge clk);
            if (go) begin
                done = 1'b0;
                @(negedge clk);
                // Break: long space, then a short mark before the frame
                if (brk) begin
                    hold(1'b0, 12 * bit_cyc);
                    hold(1'b1, 2 * bit_cyc);
                end
                hold(1'b0, bit_cyc);
                for (int i = 0; i < 8; i++) begin
                    hold(data[i], bit_cyc);
                end
                hold(1'b1, bit_cyc);
                done = 1'b1;
            end
        end
    end
endmodule : sab_remote_tx

// ===== bench/sab_checker.sv
// Checker: timing relations of the auto-baud serial port at its ports
module sab_checker (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Controls
    input wire sab_pkg::sab_cfg_t cfg,
    input wire logic autobaud_enable_set,
    input wire logic divisor_write,
    input wire logic receive_buffer_read,
    input wire logic rx_line,
    // Status
    input wire logic autobaud_enable,
    input wire logic [7:0] divisor_low_byte,
    input wire logic [7:0] divisor_high_byte,
    input wire logic receive_complete_flag,
    input wire logic receiver_idle
);
    import sab_pkg::*;
    logic [15:0] div_c, cal_c, div_q_r, gap_r, gap_nxt;
    logic rx_q_r, rise_r, rise_nxt, div_chg;

    always_comb begin
        div_c = {divisor_high_byte, divisor_low_byte};
        div_chg = div_c != div_q_r;
        case ({cfg.wide_divisor_select, cfg.high_speed_rate_select})
            2'b00: cal_c = 16'h1000;
            2'b01: cal_c = 16'h0800;
            2'b10: cal_c = 16'h0400;
            default: cal_c = 16'h0100;
        endcase
        // Saturate so a long wait for the start bit cannot wrap the gap
        gap_nxt = (gap_r == 16'hffff) ? gap_r : gap_r + 16'h0001;
        if (!autobaud_enable || div_chg) begin
            gap_nxt = 16'h0000;
        end
        rise_nxt = autobaud_enable && (rise_r || (rx_line && !rx_q_r));
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            div_q_r <= 16'h0000;
            gap_r <= 16'h0000;
            rx_q_r <= 1'b1;
            rise_r <= 1'b0;
        end else begin
            div_q_r <= div_c;
            gap_r <= gap_nxt;
            rx_q_r <= rx_line;
            rise_r <= rise_nxt;
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);

    sequence set_taken_s;
        autobaud_enable_set && cfg.async_mode && !autobaud_enable;
    endsequence
    sequence done_s;
        $fell(autobaud_enable) && $past(cfg.async_mode);
    endsequence

    set_clear_a: assert property (
        set_taken_s |=> autobaud_enable && div_c == 16'h0000)
        else $error("set did not start with a cleared divisor");
    sync_refuse_a: assert property (
        autobaud_enable_set && !cfg.async_mode && !autobaud_enable
        |=> !autobaud_enable) else $error("set taken outside async mode");
    count_gate_a: assert property (
        autobaud_enable && $past(autobaud_enable) && !rise_r
        |-> div_c == 16'h0000) else $error("counting before first rise");
    tick_rate_a: assert property (
        autobaud_enable && $past(autobaud_enable) && div_chg
        |-> gap_r >= cal_c - 16'h0001) else $error("count tick too early");
    step_one_a: assert property (
        autobaud_enable && $past(autobaud_enable) && cfg.wide_divisor_select
        |-> div_c == div_q_r || div_c == div_q_r + 16'h0001)
        else $error("divisor stepped by more than one");
    carry_byte_a: assert property (
        autobaud_enable && !cfg.wide_divisor_select
        |-> divisor_high_byte == 8'h00 || divisor_high_byte == 8'h01)
        else $error("narrow high byte is not a carry mark");
    done_flag_a: assert property (
        done_s |-> receive_complete_flag)
        else $error("measurement ended without the flag");
    idle_hold_a: assert property (
        autobaud_enable && $past(autobaud_enable) |-> receiver_idle)
        else $error("receiver left idle during measurement");
    flag_clear_a: assert property (
        receive_buffer_read && !autobaud_enable && receiver_idle
        && $past(receiver_idle) |=> !receive_complete_flag)
        else $error("buffer read did not clear the flag");
    div_hold_a: assert property (
        !autobaud_enable && !autobaud_enable_set && !divisor_write
        |=> $stable(div_c)) else $error("divisor moved while idle");
endmodule : sab_checker

bind sab_core sab_checker sab_checker_inst (
    .clk(clk), .nrst(nrst), .cfg(cfg),
    .autobaud_enable_set(autobaud_enable_set),
    .divisor_write(divisor_write),
    .receive_buffer_read(receive_buffer_read), .rx_line(rx_line),
    .autobaud_enable(autobaud_enable),
    .divisor_low_byte(divisor_low_byte),
    .divisor_high_byte(divisor_high_byte),
    .receive_complete_flag(receive_complete_flag),
    .receiver_idle(receiver_idle)
);

// ===== bench/sab_core_tb.sv
// Testbench: rate measurement in all modes, refusal, break, reception
module sab_core_tb;
    timeunit 1ns;
    timeprecision 100ps;
    import sab_pkg::*;
    logic clk, nrst, autobaud_enable_set, divisor_write, receive_buffer_read;
    logic rx_line, tx_line, autobaud_enable, receive_complete_flag;
    logic framing_error, receiver_idle, tx_busy, go, brk, done, tx_load;
    logic [15:0] divisor_wdata, bit_cyc;
    logic [7:0] divisor_low_byte, divisor_high_byte, data;
    logic [8:0] receive_buffer, tx_data;
    sab_cfg_t cfg;
    int checks = 0;
    int n_errors = 0;
    int pre_tab[4] = '{512, 256, 128, 32};
    int k_tab[4] = '{1, 3, 7, 28};

    sab_core sab_core_inst (
        .clk(clk), .nrst(nrst), .cfg(cfg),
        .autobaud_enable_set(autobaud_enable_set),
        .divisor_write(divisor_write), .divisor_wdata(divisor_wdata),
        .receive_buffer_read(receive_buffer_read),
        .tx_load(tx_load), .tx_data(tx_data), .rx_line(rx_line),
        .tx_line(tx_line), .autobaud_enable(autobaud_enable),
        .divisor_low_byte(divisor_low_byte),
        .divisor_high_byte(divisor_high_byte),
        .receive_complete_flag(receive_complete_flag),
        .receive_buffer(receive_buffer), .framing_error(framing_error),
        .receiver_idle(receiver_idle), .tx_busy(tx_busy)
    );
    sab_remote_tx sab_remote_tx_inst (
        .clk(clk), .go(go), .brk(brk), .data(data), .bit_cyc(bit_cyc),
        .rx_line(rx_line), .done(done)
    );

    task automatic check(input logic [15:0] seen, input logic [15:0] exp,
                         input string what);
        checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] %0t %s saw %h want %h", $time, what, seen, exp);
        end
    endtask : check

    task automatic report_and_stop();
        $display("checks %0d n_errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : report_and_stop

    task automatic pulse(ref logic s);
        s = 1'b1;
        @(negedge clk);
        s = 1'b0;
    endtask : pulse

    task automatic wait_for(ref logic s, input logic v, input int lim);
        for (int n = 0; n < lim && s !== v; n++) begin
            @(negedge clk);
        end
    endtask : wait_for

    task automatic send(input logic [7:0] d, input logic b, input int p);
        data = d;
        brk = b;
        bit_cyc = 16'(p);
        pulse(go);
    endtask : send

    // Bit period puts 8 bits mid-way between two counter ticks
    task automatic measure(input logic [1:0] m, input logic wob);
        int p;
        logic [15:0] e;
        p = pre_tab[m] * (2 * k_tab[m] + 1) / 2;
        e = 16'(k_tab[m]);
        cfg.wide_divisor_select = m[1];
        cfg.high_speed_rate_select = m[0];
        cfg.wake_on_break_enable = wob;
        divisor_wdata = 16'hffff;
        pulse(divisor_write);
        pulse(autobaud_enable_set);
        @(negedge clk);
        check(autobaud_enable, 1'b1, "enable");
        check({divisor_high_byte, divisor_low_byte}, 16'h0000, "clr");
        send(SAB_SYNC_CHAR, wob, p);
        repeat (3 * p) @(negedge clk);
        check(receiver_idle, 1'b1, "rx held");
        divisor_wdata = 16'h1234;
        pulse(divisor_write);
        wait_for(autobaud_enable, 1'b0, 30 * p);
        check(autobaud_enable, 1'b0, "auto clear");
        check(receive_complete_flag, 1'b1, "flag");
        check({divisor_high_byte, divisor_low_byte}, e, "count");
        check(divisor_high_byte, 8'h00, "no carry");
        wait_for(done, 1'b1, 2 * p);
        pulse(receive_buffer_read);
        @(negedge clk);
        check(receive_complete_flag, 1'b0, "flag read");
    endtask : measure

    // Nine-bit frame; needs divisor 9 in fast wide mode, 40 clocks a bit
    // Tick phase is free, so each bit is looked at mid-way through it
    task automatic send_tx(input logic [8:0] d);
        logic [10:0] f;
        f = {1'b1, d, 1'b0};
        cfg.nine_bit = 1'b1;
        tx_data = d;
        pulse(tx_load);
        check(tx_busy, 1'b1, "tx busy");
        repeat (16) @(negedge clk);
        for (int i = 0; i < 11; i++) begin
            check(tx_line, f[i], "tx bit");
            repeat (40) @(negedge clk);
        end
        check(tx_busy, 1'b0, "tx done");
    endtask : send_tx

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // About one and a half times the length of the whole sequence
    initial begin
        repeat (90000) @(posedge clk);
        n_errors++;
        $display("[FAIL] %0t watchdog expired", $time);
        report_and_stop();
    end

    initial begin
        nrst = 1'b0;
        cfg = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
        {autobaud_enable_set, divisor_write, receive_buffer_read} = 3'h0;
        tx_load = 1'b0;
        tx_data = 9'h000;
        {go, brk, data, divisor_wdata, bit_cyc} = 42'h0;
        repeat (4) @(negedge clk);
        nrst = 1'b1;
        check(autobaud_enable, 1'b0, "rst enable");
        check({divisor_high_byte, divisor_low_byte}, 16'h0000, "rst div");
        check(receive_complete_flag, 1'b0, "rst flag");
        check(tx_line, 1'b1, "rst tx");
        cfg.async_mode = 1'b0;
        pulse(autobaud_enable_set);
        @(negedge clk);
        check(autobaud_enable, 1'b0, "sync refused");
        cfg.async_mode = 1'b1;
        // Dropping async mode mid-measurement aborts without the flag
        pulse(autobaud_enable_set);
        cfg.async_mode = 1'b0;
        @(negedge clk);
        check(autobaud_enable, 1'b0, "abort");
        check(receive_complete_flag, 1'b0, "abort flag");
        cfg.async_mode = 1'b1;
        for (int m = 0; m < 4; m++) begin
            measure(2'(m), 1'b0);
        end
        measure(2'b11, 1'b1);
        cfg.wake_on_break_enable = 1'b0;
        divisor_wdata = 16'h0009;
        pulse(divisor_write);
        send(8'ha3, 1'b0, 40);
        wait_for(done, 1'b1, 500);
        check(receive_buffer, 9'h0a3, "lsb first");
        check(framing_error, 1'b0, "stop bit");
        check(receive_complete_flag, 1'b1, "rx flag");
        send_tx(9'h15a);
        report_and_stop();
    end
endmodule : sab_core_tb
